// >>> mbd_defines.vh
`ifndef MBD_DEFINES_VH
`define MBD_DEFINES_VH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define MBD_IDX_BEAT_RATE   10'h096
`define MBD_IDX_CONTROL     10'h097
`define MBD_IDX_START_OP    10'h098
`define MBD_IDX_ROUTE       10'h099

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define MBD_RST_BEAT_RATE   4'h0
`define MBD_RST_CONTROL     4'h0
`define MBD_RST_START_OP    16'h0000
`define MBD_RST_ROUTE       1'b0

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define MBD_CTL_RUNNING     3
`define MBD_CTL_BUZZ_ON     2
`define MBD_CTL_PAT_HI      1
`define MBD_CTL_PAT_LO      0

// ---------------------------------------------------------------
// Buzzer pattern codes
// ---------------------------------------------------------------
`define MBD_PAT_INTER1      2'h0
`define MBD_PAT_INTER2      2'h1
`define MBD_PAT_SINGLE      2'h2
`define MBD_PAT_CONT        2'h3

// ---------------------------------------------------------------
// Note word fields
// ---------------------------------------------------------------
`define MBD_NW_END          15
`define MBD_NW_LEN_HI       13
`define MBD_NW_LEN_LO       8
`define MBD_NW_PITCH_HI     6
`define MBD_NW_PITCH_LO     0
`define MBD_PITCH_MIN       7'h04

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define MBD_CLK_HZ          32'd10000000
`define MBD_CLK_PERIOD_NS   21'd100
`define MBD_NOTE_UNIT_NS    21'd1953125
`define MBD_BUZZ_HZ         32'd4000
`define MBD_BUZZ_HALF       (`MBD_CLK_HZ / (32'd2 * `MBD_BUZZ_HZ))
`define MBD_TONE_NUM        32'd65536
`define MBD_TONE_STEP       (32'd2 * `MBD_TONE_NUM)

// ---------------------------------------------------------------
// Bus responses
// ---------------------------------------------------------------
`define MBD_RESP_OKAY       2'h0
`define MBD_RESP_SLVERR     2'h2

`endif

// >>> mbd_top.v
`timescale 1ns/1ps
`include "mbd_defines.vh"

// Summary of operation
// R1 - Sequencer fetches consecutive note words from start address, plays each.
// R2 - Output goes to differential pin pair or converter/amplifier pair.
// R3 - 124 pitches, 63 durations and 15 tempos are available.
// R4 - Buzzer is a 4 kHz square tone with four gating modes.
// R5 - Melody owns the pins; buzzer yields while melody runs.
// R6 - Beat rate register: 4 bits, read/write, index 096h, resets zero.
// R7 - Beat code sets rate; codes 0 and 1 equal, slowest at F.
// R8 - Running flag sets on start, clears after end-marked note plays.
// R9 - Writing zero to running aborts at once; no resume.
// R10 - Reset clears running flag; sequencer idle.
// R11 - Software aborts via silent two-word melody, flag clear, request clear.
// R12 - Buzzer enable bit switches buzzer; reset clears it.
// R13 - Single tone ends at second 32 Hz falling edge, clearing enable.
// R14 - Melody start clears buzzer enable and silences buzzer.
// R15 - Pattern bits reset to zero, selecting intermittent pattern one.
// R16 - Pattern one gates tone with 8 Hz time base.
// R17 - Pattern two gates with 8 Hz while 1 Hz is low.
// R18 - Continuous mode sounds while enable bit stays one.
// R19 - Fetching an end-marked word raises melody-end request.
// R20 - New start after end word continues from new address after note.
// R21 - Software programs beat rate before starting a melody.
// R22 - Word: bit15 end, bits13-8 duration, bits6-0 pitch.
// R23 - Pitch N gives 65536/(N+2) Hz; bits 6-2 zero is silence.
// R24 - Duration 1.953125 ms times (tempo+1) times (code+1); code 0 as 1.
// R25 - End-marked note plays fully, then melody stops unless restarted.
// R26 - Pattern 00 inter1, 01 inter2, 10 single, 11 continuous.
module mbd_top
(
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [15:0] prog_addr,
    output reg         prog_rd,
    input  wire [15:0] prog_data,
    input  wire        tb_32hz,
    input  wire        tb_8hz,
    input  wire        tb_1hz,
    output reg         melody_irq_request,
    output reg         tone_out_p,
    output reg         tone_out_n,
    output reg         converter_tone_out,
    output reg         amp_tone_out
);

    // -----------------------------------------------------------
    // Sequencer states
    // -----------------------------------------------------------
    localparam ST_IDLE  = 2'd0;
    localparam ST_FETCH = 2'd1;
    localparam ST_WAIT  = 2'd2;
    localparam ST_PLAY  = 2'd3;

    // -----------------------------------------------------------
    // Register file and bus state
    // -----------------------------------------------------------
    reg [3:0]  beat_rate_code_r;
    reg        buzzer_on_r;
    reg        buzzer_pattern_hi_r;
    reg        buzzer_pattern_lo_r;
    reg [15:0] start_addr_r;
    reg        route_conv_r;
    reg        aw_full_r;
    reg        w_full_r;
    reg [9:0]  waddr_idx_r;
    reg [31:0] wdata_r;
    reg [3:0]  wstrb_r;

    // Sequencer, tone and buzzer state
    reg [1:0]  state_r;
    reg        melody_running_r;
    reg        pend_start_r;
    reg [15:0] pend_addr_r;
    reg [15:0] note_r;
    reg [31:0] tone_acc_r;
    reg        tone_lvl_r;
    reg [20:0] unit_acc_r;
    reg [10:0] note_cnt_r;
    reg [10:0] buzz_cnt_r;
    reg        buzz_lvl_r;
    reg        tb32_prev_r;
    reg [1:0]  single_edges_r;

    // -----------------------------------------------------------
    // Write decode
    // -----------------------------------------------------------
    wire       wr_fire  = aw_full_r & w_full_r & ~s_axi_bvalid;
    wire       wr_beat  = wr_fire & (waddr_idx_r == `MBD_IDX_BEAT_RATE);
    wire       wr_ctrl  = wr_fire & (waddr_idx_r == `MBD_IDX_CONTROL);
    wire       wr_start = wr_fire & (waddr_idx_r == `MBD_IDX_START_OP);
    wire       wr_route = wr_fire & (waddr_idx_r == `MBD_IDX_ROUTE);
    wire       wr_known = wr_beat | wr_ctrl | wr_start | wr_route;
    wire       ctl_lane = wstrb_r[0];
    wire [1:0] pattern  = {buzzer_pattern_hi_r, buzzer_pattern_lo_r};
    wire [15:0] start_val =
        {wstrb_r[1] ? wdata_r[15:8] : start_addr_r[15:8],
         wstrb_r[0] ? wdata_r[7:0]  : start_addr_r[7:0]};
    // R1 start op kicks sequencer
    wire       start_go = wr_start & (wstrb_r[1:0] != 2'b00);
    // R9 zero write to running aborts
    wire       abort_go = wr_ctrl & ctl_lane &
                          ~wdata_r[`MBD_CTL_RUNNING] & melody_running_r;

    // -----------------------------------------------------------
    // Note word decode
    // -----------------------------------------------------------
    // R22 field split, bits 14 and 7 unused
    wire       note_end   = note_r[`MBD_NW_END];
    wire [5:0] note_len   = note_r[`MBD_NW_LEN_HI:`MBD_NW_LEN_LO];
    wire [6:0] note_pitch = note_r[`MBD_NW_PITCH_HI:`MBD_NW_PITCH_LO];
    // R23 upper pitch bits zero mean a rest
    wire       note_rest  = (note_pitch[6:2] == 5'h00);
    // R24 duration code zero acts as one
    wire [5:0] len_eff    = (note_len == 6'h00) ? 6'h01 : note_len;
    // R7 codes 0 and 1 share the fastest rate
    wire [3:0] tp_eff     = (beat_rate_code_r == 4'h0) ? 4'h1
                                                       : beat_rate_code_r;
    // R3 full 5x7 bit product covers every tempo and duration
    wire [10:0] note_units = ({6'h00, {1'b0, tp_eff} + 5'h01} *
                              {4'h0, {1'b0, len_eff} + 7'h01});
    wire [31:0] tone_lim  = `MBD_CLK_HZ * ({25'h0, note_pitch} + 32'd2);
    wire [31:0] tone_sum  = tone_acc_r + `MBD_TONE_STEP;
    wire [20:0] unit_sum  = unit_acc_r + `MBD_CLK_PERIOD_NS;
    wire        unit_tick = (unit_sum >= `MBD_NOTE_UNIT_NS);
    wire        note_done = (state_r == ST_PLAY) & unit_tick &
                            (note_cnt_r + 11'h001 >= note_units);

    // -----------------------------------------------------------
    // AXI4-Lite write channel
    // -----------------------------------------------------------
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `MBD_RESP_OKAY;
            aw_full_r     <= 1'b0;
            w_full_r      <= 1'b0;
            waddr_idx_r   <= 10'h000;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_full_r     <= 1'b1;
                waddr_idx_r   <= s_axi_awaddr[11:2];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_full_r     <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // Both halves present: commit and answer
            if (wr_fire)
            begin
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `MBD_RESP_OKAY
                                         : `MBD_RESP_SLVERR;
            end
            // Reopen only after the response is gone, one write at a time
            if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------
    // AXI4-Lite read channel
    // -----------------------------------------------------------
    reg [31:0] rd_mux;
    reg        rd_hit;

    always @*
    begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr[11:2])
            `MBD_IDX_BEAT_RATE: rd_mux = {28'h0, beat_rate_code_r};
            `MBD_IDX_CONTROL:   rd_mux = {28'h0, melody_running_r,
                                          buzzer_on_r, pattern};
            `MBD_IDX_START_OP:  rd_mux = {16'h0, start_addr_r};
            `MBD_IDX_ROUTE:     rd_mux = {31'h0, route_conv_r};
            default:            rd_hit = 1'b0;
        endcase
    end

    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `MBD_RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_hit ? `MBD_RESP_OKAY
                                        : `MBD_RESP_SLVERR;
            end
            if (s_axi_rvalid & s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------
    // Software registers
    // -----------------------------------------------------------
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // R6 beat rate resets to zero
            beat_rate_code_r    <= `MBD_RST_BEAT_RATE;
            // R15 pattern bits reset to pattern one
            buzzer_pattern_hi_r <= 1'b0;
            buzzer_pattern_lo_r <= 1'b0;
            // R12 buzzer off after reset
            buzzer_on_r         <= 1'b0;
            start_addr_r        <= `MBD_RST_START_OP;
            route_conv_r        <= `MBD_RST_ROUTE;
        end
        else
        begin
            // R6 beat rate is plain read/write
            if (wr_beat & ctl_lane)
                beat_rate_code_r <= wdata_r[3:0];
            if (wr_route & ctl_lane)
                route_conv_r <= wdata_r[0];
            if (start_go)
                start_addr_r <= start_val;
            // R13 second 32 Hz fall ends a single tone
            if (buzzer_on_r & (pattern == `MBD_PAT_SINGLE) &
                tb32_prev_r & ~tb_32hz & (single_edges_r == 2'd1))
                buzzer_on_r <= 1'b0;
            // R14 melody start silences the buzzer
            if (start_go)
                buzzer_on_r <= 1'b0;
            // Software write comes last so it wins a same-cycle clear
            if (wr_ctrl & ctl_lane)
            begin
                // R12 enable bit set and cleared by software
                buzzer_on_r         <= wdata_r[`MBD_CTL_BUZZ_ON];
                buzzer_pattern_hi_r <= wdata_r[`MBD_CTL_PAT_HI];
                buzzer_pattern_lo_r <= wdata_r[`MBD_CTL_PAT_LO];
            end
        end
    end

    // -----------------------------------------------------------
    // Melody sequencer
    // -----------------------------------------------------------
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // R10 reset leaves sequencer idle
            state_r            <= ST_IDLE;
            melody_running_r   <= 1'b0;
            pend_start_r       <= 1'b0;
            pend_addr_r        <= 16'h0000;
            note_r             <= 16'h0000;
            prog_addr          <= 16'h0000;
            prog_rd            <= 1'b0;
            melody_irq_request <= 1'b0;
            unit_acc_r         <= 21'h000000;
            note_cnt_r         <= 11'h000;
        end
        else
        begin
            prog_rd            <= 1'b0;
            melody_irq_request <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    // R8 running flag rises on start
                    if (start_go)
                    begin
                        melody_running_r <= 1'b1;
                        prog_addr        <= start_val;
                        state_r          <= ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    prog_rd <= 1'b1;
                    state_r <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    // Memory answers one cycle after the read strobe
                    if (~prog_rd)
                    begin
                        note_r     <= prog_data;
                        unit_acc_r <= 21'h000000;
                        note_cnt_r <= 11'h000;
                        state_r    <= ST_PLAY;
                        // R19 end word raises the request on fetch
                        if (prog_data[`MBD_NW_END])
                            melody_irq_request <= 1'b1;
                    end
                end
                ST_PLAY:
                begin
                    // R24 count base units of exactly 1/512 s
                    if (unit_tick)
                    begin
                        unit_acc_r <= unit_sum - `MBD_NOTE_UNIT_NS;
                        note_cnt_r <= note_cnt_r + 11'h001;
                    end
                    else
                        unit_acc_r <= unit_sum;
                    if (note_done)
                    begin
                        // R20 queued start continues from new address
                        if (pend_start_r | start_go)
                        begin
                            prog_addr    <= start_go ? start_val : pend_addr_r;
                            pend_start_r <= 1'b0;
                            state_r      <= ST_FETCH;
                        end
                        // R25 end word plays out fully, then stop
                        else if (note_end)
                        begin
                            // R8 running flag falls after last note
                            melody_running_r <= 1'b0;
                            state_r          <= ST_IDLE;
                        end
                        else
                        begin
                            // R1 next consecutive word
                            prog_addr <= prog_addr + 16'h0001;
                            state_r   <= ST_FETCH;
                        end
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
            // Start while busy is queued for the next note boundary
            if (start_go & (state_r != ST_IDLE) & ~note_done)
            begin
                pend_start_r <= 1'b1;
                pend_addr_r  <= start_val;
            end
            // R9 abort drops position and any queued start
            if (abort_go)
            begin
                melody_running_r <= 1'b0;
                pend_start_r     <= 1'b0;
                state_r          <= ST_IDLE;
            end
        end
    end

    // -----------------------------------------------------------
    // Tone and buzzer generators
    // -----------------------------------------------------------
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tone_acc_r     <= 32'h0000_0000;
            tone_lvl_r     <= 1'b0;
            buzz_cnt_r     <= 11'h000;
            buzz_lvl_r     <= 1'b0;
            tb32_prev_r    <= 1'b0;
            single_edges_r <= 2'd0;
        end
        else
        begin
            // R23 fractional accumulator gives 65536/(N+2) Hz on average
            if (state_r != ST_PLAY)
            begin
                tone_acc_r <= 32'h0000_0000;
                tone_lvl_r <= 1'b0;
            end
            else if (tone_sum >= tone_lim)
            begin
                tone_acc_r <= tone_sum - tone_lim;
                tone_lvl_r <= ~tone_lvl_r;
            end
            else
                tone_acc_r <= tone_sum;
            // R4 free 4 kHz square wave
            if (buzz_cnt_r == `MBD_BUZZ_HALF - 11'h001)
            begin
                buzz_cnt_r <= 11'h000;
                buzz_lvl_r <= ~buzz_lvl_r;
            end
            else
                buzz_cnt_r <= buzz_cnt_r + 11'h001;
            tb32_prev_r <= tb_32hz;
            // R13 count 32 Hz falls from the moment enable is set
            if (wr_ctrl & ctl_lane & wdata_r[`MBD_CTL_BUZZ_ON] &
                ~buzzer_on_r)
                single_edges_r <= 2'd0;
            else if (buzzer_on_r & tb32_prev_r & ~tb_32hz &
                     (single_edges_r != 2'd2))
                single_edges_r <= single_edges_r + 2'd1;
        end
    end

    // -----------------------------------------------------------
    // Output steering
    // -----------------------------------------------------------
    reg buzz_gate;
    reg sig;
    reg act;

    always @*
    begin
        // R26 pattern code to gating
        case (pattern)
            // R16 pattern one follows 8 Hz
            `MBD_PAT_INTER1: buzz_gate = tb_8hz;
            // R17 pattern two needs 1 Hz low
            `MBD_PAT_INTER2: buzz_gate = tb_8hz & ~tb_1hz;
            // R13 single tone gated only by enable
            `MBD_PAT_SINGLE: buzz_gate = 1'b1;
            // R18 continuous while enabled
            `MBD_PAT_CONT:   buzz_gate = 1'b1;
            default:         buzz_gate = 1'b0;
        endcase
        // R5 melody owns the pins, even during rests and fetches
        if (melody_running_r)
        begin
            act = 1'b1;
            sig = (state_r == ST_PLAY) & ~note_rest & tone_lvl_r;
        end
        else
        begin
            act = buzzer_on_r & buzz_gate;
            sig = act & buzz_lvl_r;
        end
    end

    // Registered pins; unused path rests low
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tone_out_p         <= 1'b0;
            tone_out_n         <= 1'b0;
            converter_tone_out <= 1'b0;
            amp_tone_out       <= 1'b0;
        end
        else
        begin
            // R2 choose pin pair or converter pair
            tone_out_p         <= ~route_conv_r & act & sig;
            tone_out_n         <= ~route_conv_r & act & ~sig;
            converter_tone_out <= route_conv_r & sig;
            amp_tone_out       <= route_conv_r & sig;
        end
    end

endmodule

// >>> mbd_top_assertions.sv
`timescale 1ns/1ps
// Port-level checks on bus handshakes, fetch and pins
module mbd_top_assertions
(
    input wire sys_clk,
    input wire sys_rst,
    input wire s_axi_awready,
    input wire s_axi_arready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire prog_rd,
    input wire melody_irq_request,
    input wire tone_out_p,
    input wire tone_out_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Both legs high would short the piezo
    a_pair_never_both: assert property (!(tone_out_p && tone_out_n))
        else $error("pin pair both high");
    a_fetch_one_pulse: assert property (prog_rd |=> !prog_rd)
        else $error("fetch strobe longer than one cycle");
    a_irq_one_pulse: assert property (melody_irq_request |=> !melody_irq_request)
        else $error("end request longer than one cycle");
    a_irq_after_fetch: assert property (melody_irq_request |->
        $past(prog_rd, 2) || $past(prog_rd, 3)) else $error("request without fetch");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rresp_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address ready during response");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready during response");
endmodule
bind mbd_top mbd_top_assertions u_mbd_top_assertions (.*);

// >>> mbd_prog_mem.sv
`timescale 1ns/1ps
// Program memory holding the test melodies
module mbd_prog_mem
(
    input  wire        sys_clk,
    input  wire        prog_rd,
    input  wire [15:0] prog_addr,
    output reg  [15:0] prog_data
);
    reg [15:0] rom_r [0:3];
    initial
    begin
        rom_r[0] = 16'h0128;
        rom_r[1] = 16'h8000;
        rom_r[2] = 16'h8000;
        rom_r[3] = 16'h8004;
        prog_data = 16'h5a5a;
    end
    // Word valid only the cycle after a read; junk otherwise, never stale
    always @(posedge sys_clk)
        prog_data <= prog_rd ? rom_r[prog_addr[1:0]] : ~prog_data;
endmodule

// >>> mbd_top_tb.sv
`timescale 1ns/1ps
`include "mbd_defines.vh"
module mbd_top_tb;
    logic        sys_clk = 0, sys_rst = 1, tb_32hz = 0, tb_8hz = 1, tb_1hz = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, v;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic        s_axi_arvalid = 0, s_axi_rready = 1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, prog_rd, melody_irq_request, ta, tw;
    logic        tone_out_p, tone_out_n, converter_tone_out, amp_tone_out;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [15:0] prog_addr, prog_data;
    int          fail_count = 0, total_checks = 0, n;
    mbd_top u_mbd_top (.*);
    mbd_prog_mem u_mbd_prog_mem (.*);
    initial
        forever #50 sys_clk = ~sys_clk;
    // Half period of a square tone, in clock cycles
    function logic [31:0] exp_half(input int hz);
        return 32'd10000000 / (2 * hz);
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        begin
            total_checks++;
            if (g !== e)
            begin
                fail_count++;
                $display("unexpected at %0t: got %h exp %h", $time, g, e);
            end
        end
    endtask
    // Address and data released each on its own handshake
    task axw(input logic [11:0] a, input logic [31:0] d);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            do
            begin
                @(negedge sys_clk);
                ta = s_axi_awready & s_axi_awvalid;
                tw = s_axi_wready & s_axi_wvalid;
                @(posedge sys_clk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
            end while ((s_axi_awvalid & !ta) | (s_axi_wvalid & !tw));
            do @(negedge sys_clk); while (s_axi_bvalid !== 1'b1);
            @(posedge sys_clk);
        end
    endtask
    task axr(input logic [11:0] a);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            do
            begin
                @(negedge sys_clk);
                ta = s_axi_arready;
                @(posedge sys_clk);
            end while (ta !== 1'b1);
            s_axi_arvalid <= 1'b0;
            do @(negedge sys_clk); while (s_axi_rvalid !== 1'b1);
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge sys_clk);
        end
    endtask
    // Cycles between two changes of the positive pin
    task half(output int c);
        logic lv;
        begin
            @(negedge sys_clk);
            lv = tone_out_p;
            while (tone_out_p === lv) @(negedge sys_clk);
            lv = tone_out_p;
            c = 0;
            while (tone_out_p === lv && c < 5000)
            begin
                @(negedge sys_clk);
                c++;
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, fail_count);
            if (fail_count == 0 && total_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Watchdog: the whole run needs well under 20000 cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        print_verdict;
    end
    initial
    begin
        n = $urandom(32'hb986);
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        axr(12'h258);
        chk(rd, 32'h0);
        axr(12'h25c);
        chk(rd, 32'h0);
        repeat (4)
        begin
            v = $urandom;
            axw(12'h258, v);
            axr(12'h258);
            chk(rd, v & 32'hf);
        end
        axr(12'h300);
        chk({30'h0, rsp}, {30'h0, `MBD_RESP_SLVERR});
        $display("test registers done");
        axw(12'h25c, 32'h7);
        half(n);
        chk(n, exp_half(4000));
        axw(12'h25c, 32'h4);
        tb_8hz <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({30'h0, tone_out_p, tone_out_n}, 32'h0);
        axw(12'h260, 32'h0);
        axw(12'h260, 32'h1);
        axr(12'h25c);
        chk(rd, 32'h8);
        axw(12'h25c, 32'h3);
        axr(12'h25c);
        chk(rd, 32'h3);
        chk({30'h0, tone_out_p, tone_out_n}, 32'h0);
        axw(12'h260, 32'h3);
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end while (melody_irq_request !== 1'b1 && n < 100);
        chk({31'h0, melody_irq_request}, 32'h1);
        @(posedge sys_clk);
        axw(12'h25c, 32'h0);
        $display("test melody done");
        // Single tone cleared by the second fall of the 32 Hz base
        axw(12'h25c, 32'h6);
        for (n = 6; n > 0; n = n - 4)
        begin
            tb_32hz <= 1'b1;
            repeat (3) @(posedge sys_clk);
            tb_32hz <= 1'b0;
            repeat (3) @(posedge sys_clk);
            axr(12'h25c);
            chk(rd, n);
        end
        $display("test single tone done");
        print_verdict;
    end
endmodule
